/* rtl/sfpe_top.v */
// Page program path with page buffer, program engine and per-unit correction code.
`timescale 1ns/1ps
`include "sfpe_map.vh"
module sfpe_top #(
    parameter        MEM_AW        = 11,
    parameter        SECT_AW       = 9,
    parameter [15:0] PROG_UNIT_CYC = `SFPE_PROG_UNIT_CYC
) (
    input  wire                        mclk_i,
    input  wire                        arst_n_i,
    input  wire                        sck_i,
    input  wire                        cs_n_i,
    input  wire [3:0]                  io_i,
    input  wire                        page_size_select_bit_i,
    input  wire                        address_length_bit_i,
    input  wire [7:0]                  config_reg_one_i,
    input  wire                        four_lane_command_mode_i,
    input  wire [(1<<(MEM_AW-SECT_AW))-1:0] protect_i,
    input  wire                        clr_error_i,
    input  wire                        erase_req_i,
    input  wire [MEM_AW-SECT_AW-1:0]   erase_sector_i,
    input  wire                        flip_req_i,
    input  wire [MEM_AW+2:0]           flip_addr_i,
    input  wire                        rd_req_i,
    input  wire [MEM_AW-1:0]           rd_addr_i,
    output reg  [7:0]                  status_reg_one_o,
    output reg  [7:0]                  rd_data_o,
    output reg                         rd_valid_o,
    output reg                         rd_fixed_o,
    output reg                         rd_unchecked_o
);
    localparam MEM_BYTES = 1 << MEM_AW;
    localparam NU        = MEM_BYTES / `SFPE_UNIT_BYTES;
    localparam UAW       = MEM_AW - `SFPE_UNIT_SHIFT;
    localparam SW        = MEM_AW - SECT_AW;
    localparam [SW-1:0] OTP_SECT = {SW{1'b1}};
    localparam [1:0] PH_OPC  = 2'h0;
    localparam [1:0] PH_ADDR = 2'h1;
    localparam [1:0] PH_DATA = 2'h2;
    localparam [1:0] PH_SKIP = 2'h3;
    localparam [1:0] E_IDLE  = 2'h0;
    localparam [1:0] E_WAIT  = 2'h1;
    localparam [1:0] E_APPLY = 2'h2;

    wire [5:0]        pins;
    wire              s_sck;
    wire              s_cs_n;
    wire [3:0]        s_io;
    reg               sck_d;
    reg               cs_d;
    reg  [1:0]        phase;
    reg  [7:0]        shreg;
    reg  [3:0]        bitcnt;
    reg  [2:0]        addr_left;
    reg  [31:0]       addr;
    reg               four_lane_command_mode;
    reg               quad_data;
    reg               is_unlock;
    reg               any_data;
    reg               pg512;
    reg  [8:0]        wr_off;
    reg  [MEM_AW-1:0] pbase;
    reg  [7:0]        pbuf [0:511];
    reg  [511:0]      pvalid;
    reg  [1:0]        est;
    reg  [15:0]       wcnt;
    reg  [4:0]        u;
    reg               write_in_progress_flag;
    reg               write_unlock_latch;
    reg               perr;
    reg  [7:0]        mem [0:MEM_BYTES-1];
    reg  [7:0]        chk_mem [0:NU-1];
    reg  [NU-1:0]     used;
    reg  [NU-1:0]     dis;
    reg  [127:0]      new_unit;
    reg  [15:0]       unit_hit;
    reg  [127:0]      rd_unit;
    wire [7:0]        chk_new;
    wire [127:0]      rd_fix_unit;
    wire              rd_fix;
    integer           i;
    integer           j;
    integer           n;

    function [8:0] page_mask;
        input big;
        begin
            page_mask = big ? `SFPE_PAGE_MASK_LARGE : `SFPE_PAGE_MASK_SMALL;
        end
    endfunction

    function [MEM_AW-1:0] unit_byte;
        input [MEM_AW-1:0] base;
        input [4:0]        unit;
        input [3:0]        k;
        begin
            unit_byte = base | {{(MEM_AW-9){1'b0}}, unit, k};
        end
    endfunction

    sfpe_sync #(.W(6), .RST_VAL(`SFPE_PIN_RST)) u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({cs_n_i, sck_i, io_i}),
        .q_o      (pins)
    );
    assign s_cs_n = pins[5];
    assign s_sck  = pins[4];
    assign s_io   = pins[3:0];

    wire sck_rise = s_sck & ~sck_d & ~s_cs_n;
    wire cs_fall  = cs_d & ~s_cs_n;
    wire cs_rise  = ~cs_d & s_cs_n;
    wire lanes4   = four_lane_command_mode | (quad_data & (phase == PH_DATA));
    wire [3:0] ncnt = lanes4 ? bitcnt + 4'h4 : bitcnt + 4'h1;
    wire [7:0] nsh  = lanes4 ? {shreg[3:0], s_io} : {shreg[6:0], s_io[0]};
    wire byte_done  = sck_rise & (ncnt == 4'h8);
    wire [31:0] naddr = {addr[23:0], nsh};
    wire quad_ok    = config_reg_one_i[`SFPE_CR1_QUAD_BIT];
    wire start_prog = cs_rise & (phase == PH_DATA) & any_data & (bitcnt == 4'h0) & ~write_in_progress_flag;
    wire unlock_set = cs_rise & is_unlock & (bitcnt == 4'h0) & ~write_in_progress_flag;
    wire buf_we     = byte_done & (phase == PH_DATA);

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_d     <= 1'b0;
            cs_d      <= 1'b1;
            phase     <= PH_SKIP;
            shreg     <= 8'h00;
            bitcnt    <= 4'h0;
            addr_left <= 3'h0;
            addr      <= 32'h0000_0000;
            four_lane_command_mode       <= 1'b0;
            quad_data <= 1'b0;
            is_unlock <= 1'b0;
            any_data  <= 1'b0;
            pg512     <= 1'b0;
            wr_off    <= 9'h000;
            pbase     <= {MEM_AW{1'b0}};
            pvalid    <= 512'h0;
        end else begin
            sck_d <= s_sck;
            cs_d  <= s_cs_n;
            if (cs_fall) begin
                phase     <= PH_OPC;
                bitcnt    <= 4'h0;
                is_unlock <= 1'b0;
                any_data  <= 1'b0;
                quad_data <= 1'b0;
                four_lane_command_mode       <= four_lane_command_mode_i;
                if (!write_in_progress_flag) begin
                    pvalid <= 512'h0;
                end
            end else if (cs_rise) begin
                phase     <= PH_SKIP;
                is_unlock <= 1'b0;
            end else if (byte_done) begin
                bitcnt <= 4'h0;
                shreg  <= nsh;
                case (phase)
                    PH_OPC: begin
                        phase <= PH_SKIP;
                        if (!write_in_progress_flag && nsh == `SFPE_OP_UNLOCK) begin
                            is_unlock <= 1'b1;
                        end
                        if (!write_in_progress_flag && write_unlock_latch && (!four_lane_command_mode || quad_ok)) begin
                            if (nsh == `SFPE_OP_SL_WRITE || nsh == `SFPE_OP_SL_WRITE_LONG) begin
                                phase     <= PH_ADDR;
                                addr_left <= (nsh == `SFPE_OP_SL_WRITE_LONG ||
                                              address_length_bit_i) ?
                                             `SFPE_ADDR_BYTES_LONG : `SFPE_ADDR_BYTES_SHORT;
                            end
                            if ((nsh == `SFPE_OP_FL_WRITE || nsh == `SFPE_OP_FL_WRITE_LONG)
                                && quad_ok) begin
                                phase     <= PH_ADDR;
                                quad_data <= 1'b1;
                                addr_left <= (nsh == `SFPE_OP_FL_WRITE_LONG ||
                                              address_length_bit_i) ?
                                             `SFPE_ADDR_BYTES_LONG : `SFPE_ADDR_BYTES_SHORT;
                            end
                        end
                    end
                    PH_ADDR: begin
                        addr      <= naddr;
                        addr_left <= addr_left - 3'h1;
                        if (addr_left == 3'h1) begin
                            phase  <= PH_DATA;
                            pg512  <= page_size_select_bit_i;
                            wr_off <= naddr[8:0] & page_mask(page_size_select_bit_i);
                            pbase  <= naddr[MEM_AW-1:0] &
                                      ~{{(MEM_AW-9){1'b0}}, page_mask(page_size_select_bit_i)};
                        end
                    end
                    PH_DATA: begin
                        any_data       <= 1'b1;
                        pvalid[wr_off] <= 1'b1;
                        wr_off         <= (wr_off + 9'h001) & page_mask(pg512);
                    end
                    default: begin
                        is_unlock <= 1'b0;
                    end
                endcase
            end else if (sck_rise) begin
                shreg  <= nsh;
                bitcnt <= ncnt;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (buf_we) begin
            pbuf[wr_off] <= nsh;
        end
    end

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            est  <= E_IDLE;
            wcnt <= 16'h0000;
            u    <= 5'h00;
            write_in_progress_flag  <= 1'b0;
            write_unlock_latch  <= 1'b0;
            perr <= 1'b0;
        end else begin
            if (unlock_set) begin
                write_unlock_latch <= 1'b1;
            end
            if (clr_error_i) begin
                perr <= 1'b0;
            end
            case (est)
                E_IDLE: begin
                    if (start_prog) begin
                        if (protect_i[pbase[MEM_AW-1:SECT_AW]]) begin
                            perr <= 1'b1;
                            write_unlock_latch  <= 1'b0;
                        end else begin
                            write_in_progress_flag  <= 1'b1;
                            est  <= E_WAIT;
                            u    <= 5'h00;
                            wcnt <= PROG_UNIT_CYC - 16'h0001;
                        end
                    end
                end
                E_WAIT: begin
                    wcnt <= wcnt - 16'h0001;
                    if (wcnt == 16'h0000) begin
                        est <= E_APPLY;
                    end
                end
                E_APPLY: begin
                    u    <= u + 5'h01;
                    wcnt <= PROG_UNIT_CYC - 16'h0001;
                    est  <= E_WAIT;
                    if (u == (pg512 ? `SFPE_UNITS_LARGE : `SFPE_UNITS_SMALL)) begin
                        est <= E_IDLE;
                        write_in_progress_flag <= 1'b0;
                        write_unlock_latch <= 1'b0;
                    end
                end
                default: begin
                    est <= E_IDLE;
                end
            endcase
        end
    end

    always @* begin
        new_unit = 128'h0;
        unit_hit = 16'h0000;
        for (j = 0; j < 16; j = j + 1) begin
            unit_hit[j] = pvalid[{u, j[3:0]}];
            new_unit[j*8 +: 8] = mem[unit_byte(pbase, u, j[3:0])] &
                                 (unit_hit[j] ? pbuf[{u, j[3:0]}] : 8'hff);
        end
    end

    sfpe_ecc u_ecc_wr (
        .data_i  (new_unit),
        .chk_i   (8'h00),
        .chk_o   (chk_new),
        .data_o  (),
        .fixed_o ()
    );

    wire [MEM_AW-1:0] wr_byte = unit_byte(pbase, u, 4'h0);
    wire [UAW-1:0]    wr_unit = wr_byte[MEM_AW-1:`SFPE_UNIT_SHIFT];

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < MEM_BYTES; i = i + 1) begin
                mem[i] <= 8'hff;
            end
            for (i = 0; i < NU; i = i + 1) begin
                chk_mem[i] <= 8'h00;
            end
            used <= {NU{1'b0}};
            dis  <= {NU{1'b0}};
        end else if (est == E_APPLY && unit_hit != 16'h0000) begin
            for (i = 0; i < 16; i = i + 1) begin
                mem[unit_byte(pbase, u, i[3:0])] <= new_unit[i*8 +: 8];
            end
            if (!used[wr_unit]) begin
                used[wr_unit]    <= 1'b1;
                chk_mem[wr_unit] <= chk_new;
            end else begin
                dis[wr_unit] <= 1'b1;
            end
        end else if (erase_req_i && !write_in_progress_flag && erase_sector_i != OTP_SECT) begin
            for (i = 0; i < MEM_BYTES; i = i + 1) begin
                if (i[MEM_AW-1:SECT_AW] == erase_sector_i) begin
                    mem[i] <= 8'hff;
                end
            end
            for (i = 0; i < NU; i = i + 1) begin
                if (i[UAW-1:SECT_AW-`SFPE_UNIT_SHIFT] == erase_sector_i) begin
                    chk_mem[i] <= 8'h00;
                    used[i]    <= 1'b0;
                    dis[i]     <= 1'b0;
                end
            end
        end else if (flip_req_i) begin
            mem[flip_addr_i[MEM_AW+2:3]] <= mem[flip_addr_i[MEM_AW+2:3]] ^
                                            (8'h01 << flip_addr_i[2:0]);
        end
    end

    wire [UAW-1:0] rd_u = rd_addr_i[MEM_AW-1:`SFPE_UNIT_SHIFT];
    always @* begin
        rd_unit = 128'h0;
        for (n = 0; n < 16; n = n + 1) begin
            rd_unit[n*8 +: 8] = mem[{rd_u, n[3:0]}];
        end
    end

    sfpe_ecc u_ecc_rd (
        .data_i  (rd_unit),
        .chk_i   (chk_mem[rd_u]),
        .chk_o   (),
        .data_o  (rd_fix_unit),
        .fixed_o (rd_fix)
    );

    wire rd_checked = used[rd_u] & ~dis[rd_u];

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o        <= 8'h00;
            rd_valid_o       <= 1'b0;
            rd_fixed_o       <= 1'b0;
            rd_unchecked_o   <= 1'b0;
            status_reg_one_o <= 8'h00;
        end else begin
            rd_valid_o <= rd_req_i;
            if (rd_req_i) begin
                if (rd_checked) begin
                    rd_data_o  <= rd_fix_unit[rd_addr_i[3:0]*8 +: 8];
                    rd_fixed_o <= rd_fix;
                end else begin
                    rd_data_o  <= rd_unit[rd_addr_i[3:0]*8 +: 8];
                    rd_fixed_o <= 1'b0;
                end
                rd_unchecked_o <= dis[rd_u];
            end
            status_reg_one_o                     <= 8'h00;
            status_reg_one_o[`SFPE_SR1_WIP_BIT]  <= write_in_progress_flag;
            status_reg_one_o[`SFPE_SR1_WEL_BIT]  <= write_unlock_latch;
            status_reg_one_o[`SFPE_SR1_PERR_BIT] <= perr;
        end
    end
endmodule

/* rtl/sfpe_map.vh */
// Opcodes, field positions, sizes and timing counts of the page program path.
`ifndef SFPE_MAP_VH
`define SFPE_MAP_VH
`define SFPE_OP_UNLOCK          8'h06
`define SFPE_OP_SL_WRITE        8'h02
`define SFPE_OP_SL_WRITE_LONG   8'h12
`define SFPE_OP_FL_WRITE        8'h32
`define SFPE_OP_FL_WRITE_LONG   8'h34
`define SFPE_ADDR_BYTES_SHORT   3'h3
`define SFPE_ADDR_BYTES_LONG    3'h4
`define SFPE_UNIT_SHIFT         4
`define SFPE_UNIT_BYTES         16
`define SFPE_CHK_BITS           8
`define SFPE_PAGE_MASK_SMALL    9'h0ff
`define SFPE_PAGE_MASK_LARGE    9'h1ff
`define SFPE_UNITS_SMALL        5'h0f
`define SFPE_UNITS_LARGE        5'h1f
`define SFPE_SR1_WIP_BIT        0
`define SFPE_SR1_WEL_BIT        1
`define SFPE_SR1_PERR_BIT       6
`define SFPE_CR1_QUAD_BIT       1
`define SFPE_PIN_RST            6'h20
`define SFPE_CLK_NS             8
`define SFPE_PROG_UNIT_NS       100
`define SFPE_PROG_UNIT_CYC      ((`SFPE_PROG_UNIT_NS + `SFPE_CLK_NS - 1) / `SFPE_CLK_NS)
`endif

/* rtl/sfpe_sync.v */
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`include "sfpe_map.vh"
module sfpe_sync #(
    parameter       W       = 6,
    parameter [5:0] RST_VAL = `SFPE_PIN_RST
) (
    input  wire         mclk_i,
    input  wire         arst_n_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= RST_VAL[W-1:0];
            q_o  <= RST_VAL[W-1:0];
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* rtl/sfpe_ecc.v */
// Single error correcting code over one 16-byte unit with 8 check bits.
`timescale 1ns/1ps
module sfpe_ecc (
    input  wire [127:0] data_i,
    input  wire [7:0]   chk_i,
    output reg  [7:0]   chk_o,
    output reg  [127:0] data_o,
    output reg          fixed_o
);
    reg [7:0] syn;
    integer   p;
    integer   idx;

    // Data bit k takes the k-th nonzero code word that is not a power of two.
    always @* begin
        chk_o  = 8'h00;
        syn    = 8'h00;
        data_o = data_i;
        idx    = 0;
        for (p = 3; p < 256; p = p + 1) begin
            if (((p & (p - 1)) != 0) && (idx < 128)) begin
                if (data_i[idx]) begin
                    chk_o = chk_o ^ p[7:0];
                end
                idx = idx + 1;
            end
        end
        syn = chk_o ^ chk_i;
        idx = 0;
        for (p = 3; p < 256; p = p + 1) begin
            if (((p & (p - 1)) != 0) && (idx < 128)) begin
                if (syn == p[7:0]) begin
                    data_o[idx] = ~data_i[idx];
                end
                idx = idx + 1;
            end
        end
        fixed_o = (syn != 8'h00);
    end
endmodule

/* verif/sfpe_host.sv */
// Host model that drives the serial clock, select and data lines.
`timescale 1ns/1ps
module sfpe_host (
    input  wire       mclk_i,
    output reg        sck_o,
    output reg        cs_n_o,
    output reg  [3:0] io_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
    end
    task xfer(input [7:0] b, input integer n, input integer w);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge mclk_i);
                cs_n_o <= 1'b0;
                sck_o <= 1'b0;
                io_o <= (w == 4) ? b[7-4*i -: 4] : {{3{~b[7-i]}}, b[7-i]};
                repeat (5) @(posedge mclk_i);
                sck_o <= 1'b1;
                repeat (4) @(posedge mclk_i);
            end
        end
    endtask
    task fin;
        begin
            @(posedge mclk_i);
            sck_o <= 1'b0;
            repeat (5) @(posedge mclk_i);
            cs_n_o <= 1'b1;
            io_o <= ~io_o;
            repeat (10) @(posedge mclk_i);
        end
    endtask
endmodule

/* verif/sfpe_top_chk.sv */
// Assertions on the ports of the page program path.
`timescale 1ns/1ps
module sfpe_top_chk #(
    parameter [15:0] PROG_UNIT_CYC = 16'h000d
) (
    input wire       mclk_i,
    input wire       arst_n_i,
    input wire       cs_n_i,
    input wire       clr_error_i,
    input wire       rd_req_i,
    input wire [7:0] status_reg_one_o,
    input wire       rd_valid_o,
    input wire       rd_fixed_o,
    input wire       rd_unchecked_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    reg [15:0] busy_cnt;
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= status_reg_one_o[0] ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    sequence s_busy_end;
        $fell(status_reg_one_o[0]);
    endsequence
    property p_rd_ans; rd_req_i |=> rd_valid_o; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_rd_quiet; !rd_req_i |=> !rd_valid_o; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
    property p_flags; rd_valid_o |-> !(rd_fixed_o && rd_unchecked_o); endproperty
    a_flags: assert property (p_flags) else $error("fix on unchecked unit");
    property p_rsv; (status_reg_one_o & 8'hbc) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("unused status bit set");
    property p_busy_cs; $rose(status_reg_one_o[0]) |-> cs_n_i && $past(cs_n_i, 2); endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("busy while selected");
    property p_busy_latch; status_reg_one_o[0] |-> status_reg_one_o[1]; endproperty
    a_busy_latch: assert property (p_busy_latch) else $error("busy without latch");
    property p_latch_clr; s_busy_end |-> ##[0:2] !status_reg_one_o[1]; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after program");
    property p_busy_len;
        s_busy_end |-> (busy_cnt == 16 * (PROG_UNIT_CYC + 1) || busy_cnt == 32 * (PROG_UNIT_CYC + 1));
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_err_alone; $rose(status_reg_one_o[6]) |-> !status_reg_one_o[0]; endproperty
    a_err_alone: assert property (p_err_alone) else $error("error with busy");
    property p_err_hold; $fell(status_reg_one_o[6]) |-> $past(clr_error_i, 2); endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped alone");
endmodule
bind sfpe_top sfpe_top_chk #(.PROG_UNIT_CYC(PROG_UNIT_CYC)) u_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .clr_error_i(clr_error_i),
    .rd_req_i(rd_req_i), .status_reg_one_o(status_reg_one_o), .rd_valid_o(rd_valid_o),
    .rd_fixed_o(rd_fixed_o), .rd_unchecked_o(rd_unchecked_o));

/* verif/sfpe_top_tb.sv */
// Self-checking bench for the page program path.
`timescale 1ns/1ps
module sfpe_top_tb;
    reg         mclk_i, arst_n_i, psel, alen, fmode, clr, ers, flp, rdq;
    reg  [7:0]  cfg;
    reg  [3:0]  prot;
    reg  [1:0]  esec;
    reg  [13:0] fa;
    reg  [10:0] rda;
    wire        sck, cs_n, rdv, rdf, rdu;
    wire [3:0]  io;
    wire [7:0]  sr, rdd;
    integer     error_cnt, compares, k;
    sfpe_host u_host (.mclk_i(mclk_i), .sck_o(sck), .cs_n_o(cs_n), .io_o(io));
    sfpe_top #(.PROG_UNIT_CYC(16'h0002)) DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .sck_i(sck), .cs_n_i(cs_n), .io_i(io), .page_size_select_bit_i(psel),
        .address_length_bit_i(alen), .config_reg_one_i(cfg), .four_lane_command_mode_i(fmode),
        .protect_i(prot), .clr_error_i(clr), .erase_req_i(ers), .erase_sector_i(esec),
        .flip_req_i(flp), .flip_addr_i(fa), .rd_req_i(rdq), .rd_addr_i(rda),
        .status_reg_one_o(sr), .rd_data_o(rdd), .rd_valid_o(rdv), .rd_fixed_o(rdf),
        .rd_unchecked_o(rdu));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task test_done;
        begin
            $display("compares %0d errors %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] nm, input [15:0] s, input [15:0] e);
        begin
            compares = compares + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    task rd(input [10:0] a, input [7:0] e, input u, input f);
        begin
            @(posedge mclk_i);
            rdq <= 1'b1;
            rda <= a;
            @(posedge mclk_i);
            rdq <= 1'b0;
            #1;
            chk("read", {rdv, rdu, rdf, rdd}, {1'b1, u, f, e});
        end
    endtask
    task evt(input e, input [13:0] v);
        begin
            @(posedge mclk_i);
            ers <= e;
            flp <= !e;
            esec <= v[1:0];
            fa <= v;
            @(posedge mclk_i);
            ers <= 1'b0;
            flp <= 1'b0;
        end
    endtask
    task prog(input [7:0] op, input integer na, input [31:0] a, input [7:0] d0,
              input integer n, input integer wc, input integer wd);
        integer i;
        begin
            u_host.xfer(op, 8 / wc, wc);
            for (i = na - 1; i >= 0; i = i - 1) begin
                u_host.xfer(a[8*i +: 8], 8 / wc, wc);
            end
            for (i = 0; i < n; i = i + 1) begin
                u_host.xfer(d0 ^ i[7:0], 8 / wd, wd);
            end
            if (n == 0) begin
                u_host.xfer(8'h00, 4 / wd, wd);
            end
            u_host.fin;
        end
    endtask
    task unlock;
        begin
            u_host.xfer(8'h06, 8, 1);
            u_host.fin;
        end
    endtask
    task idle;
        integer t;
        begin
            t = 0;
            while (sr[0] !== 1'b0 && t < 500) begin
                @(posedge mclk_i);
                t = t + 1;
            end
            if (t == 500) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] busy exp 0 seen 1");
                test_done;
            end
        end
    endtask
    initial begin
        {psel, alen, fmode, clr, ers, flp, rdq} = 7'h00;
        cfg = 8'h00;
        prot = 4'h0;
        esec = 2'h0;
        fa = 14'h0000;
        rda = 11'h000;
        error_cnt = 0;
        compares = 0;
        arst_n_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        chk("status", sr, 8'h00);
        prog(8'h02, 3, 32'h0000_0010, 8'h00, 1, 1, 1);
        chk("status", sr, 8'h00);
        rd(11'h010, 8'hff, 1'b0, 1'b0);
        $display("test locked end");
        unlock;
        chk("status", sr, 8'h02);
        prog(8'h02, 3, 32'h0000_0000, 8'ha0, 16, 1, 1);
        chk("status", sr, 8'h03);
        idle;
        chk("status", sr, 8'h00);
        for (k = 0; k < 16; k = k + 1) begin
            rd(k[10:0], 8'ha0 ^ k[7:0], 1'b0, 1'b0);
        end
        rd(11'h010, 8'hff, 1'b0, 1'b0);
        evt(1'b0, {11'h003, 3'h0});
        rd(11'h003, 8'ha3, 1'b0, 1'b1);
        $display("test single end");
        unlock;
        prog(8'h02, 3, 32'h0000_0005, 8'h00, 1, 1, 1);
        idle;
        rd(11'h005, 8'h00, 1'b1, 1'b0);
        evt(1'b0, {11'h006, 3'h0});
        rd(11'h006, 8'ha7, 1'b1, 1'b0);
        evt(1'b1, 14'h0000);
        rd(11'h005, 8'hff, 1'b0, 1'b0);
        $display("test reprogram end");
        unlock;
        prog(8'h12, 4, 32'h0000_00fe, 8'h30, 4, 1, 1);
        idle;
        rd(11'h0fe, 8'h30, 1'b0, 1'b0);
        rd(11'h001, 8'h33, 1'b0, 1'b0);
        rd(11'h002, 8'hff, 1'b0, 1'b0);
        rd(11'h100, 8'hff, 1'b0, 1'b0);
        $display("test wrap end");
        unlock;
        prog(8'h32, 3, 32'h0000_0200, 8'h55, 2, 1, 4);
        chk("status", sr, 8'h02);
        cfg <= 8'h02;
        alen <= 1'b1;
        prog(8'h32, 4, 32'h0000_0200, 8'h55, 2, 1, 4);
        idle;
        rd(11'h201, 8'h54, 1'b0, 1'b0);
        unlock;
        fmode <= 1'b1;
        psel <= 1'b1;
        prog(8'h34, 4, 32'h0000_0300, 8'h66, 2, 4, 4);
        idle;
        fmode <= 1'b0;
        rd(11'h300, 8'h66, 1'b0, 1'b0);
        rd(11'h301, 8'h67, 1'b0, 1'b0);
        $display("test four lane end");
        prot <= 4'h4;
        unlock;
        prog(8'h02, 4, 32'h0000_0400, 8'h00, 1, 1, 1);
        chk("status", sr, 8'h40);
        @(posedge mclk_i);
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        prot <= 4'h0;
        repeat (2) @(posedge mclk_i);
        chk("status", sr, 8'h00);
        unlock;
        prog(8'h02, 4, 32'h0000_0180, 8'h00, 0, 1, 1);
        chk("status", sr, 8'h02);
        rd(11'h180, 8'hff, 1'b0, 1'b0);
        $display("test refused end");
        prog(8'h02, 4, 32'h0000_0600, 8'h0f, 1, 1, 1);
        idle;
        unlock;
        prog(8'h02, 4, 32'h0000_0601, 8'h00, 1, 1, 1);
        idle;
        evt(1'b1, 14'h0003);
        rd(11'h601, 8'h00, 1'b1, 1'b0);
        $display("test otp end");
        test_done;
    end
endmodule
